// [nvt_pkg.sv]
// package for the nonvolatile cycle and timer controller
// assumes a wishbone classic slave with byte-index offsets times four
package nvt_pkg;
    // register indices, byte address is four times the index
    localparam logic [2:0] NVT_IDX_ADDR   = 3'h1;
    localparam logic [2:0] NVT_IDX_DATA   = 3'h3;
    localparam logic [2:0] NVT_IDX_CTRL   = 3'h4;
    localparam logic [2:0] NVT_IDX_RELOAD = 3'h5;
    localparam logic [2:0] NVT_IDX_COUNT  = 3'h6;
    localparam logic [2:0] NVT_IDX_TEST   = 3'h7;
    // control register field positions
    localparam int NVT_B_RUN  = 7;
    localparam int NVT_B_IEN  = 6;
    localparam int NVT_B_FLAG = 5;
    localparam int NVT_B_CIP  = 4;
    localparam int NVT_B_MC   = 3;
    localparam int NVT_B_MB   = 2;
    localparam int NVT_B_MA   = 1;
    // reset value of every register
    localparam logic [7:0] NVT_RST_VAL = 8'h00;
    // prescaler: one count every 480 crystal periods
    localparam int NVT_PRESCALE = 480;
    // sequencer states
    typedef enum logic [1:0] {NVT_IDLE, NVT_ERASE, NVT_WRITE} nvt_seq_t;
    // control bits gathered
    typedef struct packed {
        logic       run;
        logic       ien;
        logic       flag;
        logic       cip;
        logic [2:0] mode;  // mode_bit_c, mode_bit_b, mode_bit_a
    } nvt_ctrl_t;
    // nonvolatile array request
    typedef struct packed {
        logic       erase;
        logic       write;
        logic [4:0] page;
    } nvt_op_t;
endpackage : nvt_pkg

// [nvt_prescale.sv]
// prescaler giving one tick every DIV clocks while enabled
// assumes a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module nvt_prescale
    import nvt_pkg::*;
#(
    parameter int DIV = NVT_PRESCALE
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic run_i,
    input  wire logic restart_i,
    // tick
    output var  logic tick_o
);
    initial if (DIV < 2 || DIV > 65535) $error("prescale out of range");
    typedef struct packed {
        logic [15:0] cnt;
    } nvt_ps_t;
    nvt_ps_t st_r, st_nxt;
    // count down while running, freeze otherwise
    always_comb begin
        st_nxt = st_r;
        if (restart_i) begin
            st_nxt.cnt = 16'(DIV - 1);
        end else if (run_i) begin
            if (st_r.cnt == 16'h0000) begin
                st_nxt.cnt = 16'(DIV - 1);
            end else begin
                st_nxt.cnt = st_r.cnt - 16'h0001;
            end
        end
    end
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    // tick only while run is high, so a freeze never lets a stale tick through
    assign tick_o = run_i && st_r.cnt == 16'h0000;
endmodule : nvt_prescale
`default_nettype wire

// [nvt_ctrl.sv]
// nonvolatile page cycle controller with shared reload down-counter
// assumes a wishbone classic master; stop mode gates via stop_i
//
// What the document asks of this block and of its software
// [R1] erase page clears flagged bytes in one interval
// [R2] erase page leaves the address unchanged
// [R3] software starts erase with all mode bits
// [R4] 8-bit counter decrements every 480 clocks
// [R5] cycle start loads count from reload
// [R6] erase/write reloads for second write interval
// [R7] final underflow stops, flags, clears control
// [R8] software loads reload for five ms
// [R9] run bit reloads, underflow sets flag, continues
// [R10] clearing run holds count; restart from reload
// [R11] count readable on the fly, undisturbed
// [R12] set flag with enable raises interrupt request
// [R13] service routine clears flag itself
// [R14] software may set flag, same request
// [R15] reset clears all registers to zero
// [R16] idle mode keeps sequencer and timer running
// [R17] stop mode freezes timer, resumes later
// [R18] software avoids stop during a cycle
// [R19] control register layout at offset four
// [R20] seven-bit address, two low bits byte
// [R21] count read-only, reload read/write
// [R22] data write loads latch, sets flag
// [R23] write ORs latches, erase/write copies them
// [R24] data read returns byte, increments address
// [R25] mode decode: b write, c erase/write
// [R26] software avoids register writes mid cycle
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module nvt_ctrl
    import nvt_pkg::*;
#(
    parameter int DIV = NVT_PRESCALE
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output var  logic [31:0] dat_o,
    output var  logic        ack_o,
    // power mode: high while the clock would be stopped
    input  wire logic        stop_i,
    // interrupt request to the core
    output var  logic        irq_o,
    // visible cycle status
    output var  logic        busy_o
);
    initial if (DIV != NVT_PRESCALE && DIV < 2) $error("bad prescale");

    // all state of the block
    typedef struct packed {
        logic [6:0]  addr;     // page_number and page_byte_sel
        nvt_ctrl_t   ctrl;
        logic [7:0]  reload;
        logic [7:0]  count;
        logic [31:0] latch;    // four page latches
        logic [3:0]  bsel;     // byte_select_flag_0..3
        nvt_seq_t    seq;
        logic [31:0] dato;
        logic        ack;
        logic        irq;
    } nvt_st_t;
    nvt_st_t st_r, st_nxt;

    // nonvolatile byte array, 128 bytes
    logic [7:0] mem_r [0:127];

    // access decode
    logic       req;
    logic       wr_lo;
    logic [2:0] idx;
    logic       tick;
    logic       tmr_go;
    logic       restart;
    logic       ctrl_wr;   // control register write taken
    logic       last_tick; // tick that ends an interval
    assign req   = cyc_i && stb_i && !st_r.ack;
    assign wr_lo = req && we_i && sel_i[0];
    assign idx   = adr_i[4:2];
    assign ctrl_wr   = wr_lo && idx == NVT_IDX_CTRL;
    assign last_tick = tick && st_r.count == 8'h00;

    // counting runs during a cycle or with run set; frozen in stop [R16] [R17]
    assign tmr_go  = (st_r.seq != NVT_IDLE || st_r.ctrl.run) && !stop_i;
    // prescaler phase restarts whenever the count is freshly loaded [R5] [R10]
    assign restart = ctrl_wr && ((dat_i[NVT_B_CIP] && !st_r.ctrl.cip)
                     || (dat_i[NVT_B_RUN] && !st_r.ctrl.run));

    // prescaler gives one tick per 480 clocks [R4]
    nvt_prescale #(
        .DIV(DIV)
    ) u_ps (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .run_i    (tmr_go),
        .restart_i(restart),
        .tick_o   (tick)
    );

    // control byte packer
    function automatic logic [7:0] ctrl_byte(input nvt_ctrl_t c);
        ctrl_byte = {c.run, c.ien, c.flag, c.cip, c.mode, 1'b0}; // [R19]
    endfunction : ctrl_byte

    // next state
    always_comb begin
        logic under;
        under  = 1'b0;
        st_nxt = st_r;
        st_nxt.ack = req;
        // register reads, unmapped read zero
        if (req && !we_i) begin
            unique case (idx)
                NVT_IDX_ADDR:   st_nxt.dato = {25'h0, st_r.addr};           // [R20]
                NVT_IDX_DATA:   st_nxt.dato = {24'h0, mem_r[st_r.addr]};    // [R24]
                NVT_IDX_CTRL:   st_nxt.dato = {24'h0, ctrl_byte(st_r.ctrl)};
                NVT_IDX_RELOAD: st_nxt.dato = {24'h0, st_r.reload};
                NVT_IDX_COUNT:  st_nxt.dato = {24'h0, st_r.count};          // [R11]
                default:        st_nxt.dato = 32'h0;
            endcase
            if (idx == NVT_IDX_DATA) begin
                st_nxt.addr = st_r.addr + 7'h01;                            // [R24]
            end
        end
        // timer counting
        if (tick) begin
            if (st_r.count == 8'h00) begin
                under = 1'b1;
                st_nxt.count = st_r.reload;                                 // [R6] [R9]
            end else begin
                st_nxt.count = st_r.count - 8'h01;                          // [R4]
            end
        end
        // sequencer on underflow
        if (under) begin
            unique case (st_r.seq)
                NVT_ERASE: begin
                    if (st_r.ctrl.mode[2] && !st_r.ctrl.mode[1]) begin
                        st_nxt.seq = NVT_WRITE;                             // [R6]
                    end else begin
                        st_nxt.seq       = NVT_IDLE;                        // [R7] [R2]
                        st_nxt.ctrl.cip  = 1'b0;
                        st_nxt.ctrl.mode = 3'h0;
                        st_nxt.ctrl.flag = 1'b1;
                    end
                end
                NVT_WRITE: begin
                    st_nxt.seq       = NVT_IDLE;                            // [R7]
                    st_nxt.ctrl.cip  = 1'b0;
                    st_nxt.ctrl.mode = 3'h0;
                    st_nxt.ctrl.flag = 1'b1;
                    st_nxt.addr      = {st_r.addr[6:2] + 5'h01, 2'b00};
                    st_nxt.bsel      = 4'h0;
                end
                NVT_IDLE: begin
                    st_nxt.ctrl.flag = 1'b1;                                // [R9]
                end
            endcase
        end
        // register writes; hardware flag set wins over software clear only while run is set
        if (wr_lo) begin
            unique case (idx)
                NVT_IDX_ADDR: st_nxt.addr = dat_i[6:0];                     // [R20]
                NVT_IDX_DATA: begin
                    st_nxt.latch[8*st_r.addr[1:0] +: 8] = dat_i[7:0];       // [R22]
                    st_nxt.bsel[st_r.addr[1:0]] = 1'b1;
                    if (st_r.ctrl.mode == 3'b010 && st_r.addr[1:0] != 2'b11) begin
                        st_nxt.addr = st_r.addr + 7'h01;                    // [R25]
                    end
                end
                NVT_IDX_CTRL: begin
                    st_nxt.ctrl.run  = dat_i[NVT_B_RUN];
                    st_nxt.ctrl.ien  = dat_i[NVT_B_IEN];
                    st_nxt.ctrl.flag = dat_i[NVT_B_FLAG] | (under && st_r.ctrl.run); // [R14]
                    st_nxt.ctrl.cip  = dat_i[NVT_B_CIP];
                    st_nxt.ctrl.mode = {dat_i[NVT_B_MC], dat_i[NVT_B_MB], dat_i[NVT_B_MA]};
                    if (dat_i[NVT_B_CIP] && !st_r.ctrl.cip) begin
                        st_nxt.count = st_r.reload;                         // [R5]
                        st_nxt.seq   = (dat_i[NVT_B_MB] && !dat_i[NVT_B_MC]
                                        && !dat_i[NVT_B_MA]) ? NVT_WRITE
                                                             : NVT_ERASE;   // [R25] [R1]
                    end else if (dat_i[NVT_B_RUN] && !st_r.ctrl.run) begin
                        st_nxt.count = st_r.reload;                         // [R9] [R10]
                    end
                end
                NVT_IDX_RELOAD: st_nxt.reload = dat_i[7:0];                 // [R21]
                default: ;
            endcase
        end
        st_nxt.irq = st_nxt.ctrl.flag && st_nxt.ctrl.ien;                  // [R12]
    end

    // state register, reset clears all [R15]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // array update at end of each erase or write interval, none while idle [R1] [R23]
    always_ff @(posedge clk_i) begin
        if (tick && st_r.count == 8'h00 && st_r.seq != NVT_IDLE) begin
            for (int i = 0; i < 4; i++) begin
                if (st_r.bsel[i]) begin
                    if (st_r.seq == NVT_ERASE) begin
                        mem_r[{st_r.addr[6:2], 2'(i)}] <= 8'h00;
                    end else begin
                        mem_r[{st_r.addr[6:2], 2'(i)}] <=
                            mem_r[{st_r.addr[6:2], 2'(i)}] | st_r.latch[8*i +: 8];
                    end
                end
            end
        end
    end

    assign dat_o  = st_r.dato;
    assign ack_o  = st_r.ack;
    assign irq_o  = st_r.irq;
    assign busy_o = st_r.ctrl.cip;

    // assertions
    a_reset_clear: assert property (@(posedge clk_i) rst_i |=> st_r.count == 8'h00
        && ctrl_byte(st_r.ctrl) == 8'h00) else $error("reset left state"); // [R15]
    a_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == $past(st_nxt.ctrl.flag && st_nxt.ctrl.ien)) else $error("irq wrong"); // [R12]
    a_stop_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_i && !req |=> st_r.count == $past(st_r.count)) else $error("count moved"); // [R17]
    a_end_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(st_r.ctrl.cip) && !$past(wr_lo) |-> st_r.ctrl.flag && st_r.ctrl.mode == 3'h0)
        else $error("end of cycle wrong"); // [R7]
    a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack held");
    a_erase_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(st_r.seq) == NVT_ERASE && st_r.seq == NVT_IDLE && !$past(req)
        |-> st_r.addr == $past(st_r.addr)) else $error("erase moved address"); // [R2]
    a_bit0_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(idx) == NVT_IDX_CTRL && !$past(we_i) |-> dat_o[0] == 1'b0)
        else $error("bit zero set"); // [R19]
    a_run_load: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lo && idx == NVT_IDX_CTRL && dat_i[NVT_B_RUN] && !st_r.ctrl.run && !dat_i[NVT_B_CIP]
        |=> st_r.count == $past(st_r.reload)) else $error("no reload"); // [R10]
    // every taken request is acked on the next edge
    a_ack_taken: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> ack_o) else $error("request not acked");
    // an ack always follows a taken request
    a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> $past(req)) else $error("ack without request");
    // read data carries the byte in the low lane only
    a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> dat_o[31:8] == 24'h000000) else $error("upper lanes set");
    // address register bit seven reads zero
    a_addr_top: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(idx) == NVT_IDX_ADDR && !$past(we_i) |-> dat_o[7] == 1'b0)
        else $error("address bit seven set"); // [R20]
    // writes to the count register are ignored
    a_count_ro: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lo && idx == NVT_IDX_COUNT && !tick |=> st_r.count == $past(st_r.count))
        else $error("count written"); // [R21]
    // reload register takes the written byte
    a_reload_wr: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lo && idx == NVT_IDX_RELOAD |=> st_r.reload == $past(dat_i[7:0]))
        else $error("reload not written"); // [R21]
    // one decrement per tick above zero
    a_tick_dec: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && st_r.count != 8'h00 && !ctrl_wr
        |=> st_r.count == $past(st_r.count) - 8'h01) else $error("no decrement"); // [R4]
    // underflow reloads the count
    a_under_load: assert property (@(posedge clk_i) disable iff (rst_i)
        last_tick && !ctrl_wr |=> st_r.count == $past(st_r.reload))
        else $error("no reload on underflow"); // [R6] [R9]
    // without a tick or load the count holds
    a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !tick && !ctrl_wr |=> st_r.count == $past(st_r.count))
        else $error("count drifted"); // [R10] [R11]
    // free-running underflow sets the flag
    a_free_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        last_tick && st_r.seq == NVT_IDLE |=> st_r.ctrl.flag)
        else $error("flag not set"); // [R9]
    // erase/write moves on to the write interval
    a_erase_next: assert property (@(posedge clk_i) disable iff (rst_i)
        last_tick && st_r.seq == NVT_ERASE && st_r.ctrl.mode == 3'b100
        |=> st_r.seq == NVT_WRITE && st_r.ctrl.cip) else $error("no write phase"); // [R6]
    // write interval end stops the cycle
    a_write_end: assert property (@(posedge clk_i) disable iff (rst_i)
        last_tick && st_r.seq == NVT_WRITE && !ctrl_wr
        |=> st_r.seq == NVT_IDLE && !st_r.ctrl.cip && st_r.ctrl.flag)
        else $error("write not ended"); // [R7]
    // data read steps the address
    a_read_step: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && idx == NVT_IDX_DATA && !(last_tick && st_r.seq == NVT_WRITE)
        |=> st_r.addr == $past(st_r.addr) + 7'h01) else $error("no read step"); // [R24]
    // the request level follows flag and enable
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == (st_r.ctrl.flag && st_r.ctrl.ien)) else $error("irq level wrong"); // [R12]
    // no tick reaches the counter in stop mode
    a_stop_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_i |-> !tick) else $error("tick in stop"); // [R17]
endmodule : nvt_ctrl
`default_nettype wire

// [nvt_core_model.sv]
// core-side model: classic wishbone master for the controller registers
// assumes the slave acks each request once, a cycle after taking it
`timescale 1ns/10ps
`default_nettype none
module nvt_core_model (
    // clock
    input  wire logic        clk_i,
    // wishbone master side
    output var  logic        cyc_o,
    output var  logic        stb_o,
    output var  logic        we_o,
    output var  logic [3:0]  sel_o,
    output var  logic [4:0]  adr_o,
    output var  logic [31:0] dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    // idle bus from time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        sel_o = 4'h1;
        adr_o = 5'h00;
        dat_o = 32'h0;
    end
    // one cycle, held until ack; read byte taken at that same edge
    task automatic xfer(input logic w, input logic [2:0] i, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {i, 2'b00};
        dat_o <= {24'h0, d};
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        dat_o <= ~dat_o; // released data must not keep its value
    endtask : xfer
endmodule : nvt_core_model
`default_nettype wire

// [nvt_ctrl_tb.sv]
// self-checking bench for the nonvolatile cycle and timer controller
// assumes nvt_core_model as bus master and a prescaler shortened to 4
`timescale 1ns/10ps
`default_nettype none
module nvt_ctrl_tb
    import nvt_pkg::*;
;
    localparam int         DIV = 4;                    // shortened prescale
    localparam logic [7:0] RL  = 8'h03;                // short page reload
    localparam int         IVL = (int'(RL) + 1) * DIV; // one interval in clocks
    logic        clk_i;
    logic        rst_i;
    logic        stop_i;
    logic        cyc, stb, we, ack, irq_o, busy_o;
    logic [3:0]  sel;
    logic [4:0]  adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  q, c0;
    int          err_total;
    int          n_checks;
    int          k;
    // bus master and device
    nvt_core_model core (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .sel_o(sel),
        .adr_o(adr), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
    nvt_ctrl #(.DIV(DIV)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .stop_i(stop_i), .irq_o(irq_o), .busy_o(busy_o));
    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        logic [7:0] x;
        core.xfer(1'b1, i, d, x);
    endtask : wr
    task automatic rd(input logic [2:0] i, output logic [7:0] d);
        core.xfer(1'b0, i, 8'h00, d);
    endtask : rd
    // verdict and end of run
    task automatic conclude();
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    // start a page cycle, time busy against n intervals
    task automatic page(input logic [7:0] c, input int n);
        int t;
        t = 0;
        wr(NVT_IDX_CTRL, c); // only while idle
        @(negedge clk_i);
        while (busy_o === 1'b1 && t < 999) begin
            @(negedge clk_i);
            t++;
        end
        chk({7'h0, t > n * IVL - 8 && t < n * IVL + 8}, 8'h01);
    endtask : page
    // clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // watchdog
    initial begin
        #100000;
        err_total++;
        conclude();
    end
    // main sequence
    initial begin
        err_total = 0;
        n_checks  = 0;
        rst_i     = 1'b1;
        stop_i    = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(i == 3 ? NVT_IDX_ADDR : 3'(i), q);
            chk(q, NVT_RST_VAL);
        end
        // layout, read-only count, reload read/write
        wr(NVT_IDX_ADDR, 8'hff);
        rd(NVT_IDX_ADDR, q);
        chk(q, 8'h7f);
        wr(NVT_IDX_CTRL, 8'h41);
        rd(NVT_IDX_CTRL, q);
        chk(q, 8'h40);
        wr(NVT_IDX_CTRL, 8'h00);
        wr(NVT_IDX_COUNT, 8'h55);
        rd(NVT_IDX_COUNT, q);
        chk(q, 8'h00);
        wr(NVT_IDX_RELOAD, RL);
        rd(NVT_IDX_RELOAD, q);
        chk(q, RL);
        // latches 0 and 2, erase/write takes two intervals
        wr(NVT_IDX_ADDR, 8'h04);
        wr(NVT_IDX_DATA, 8'h5a);
        wr(NVT_IDX_ADDR, 8'h06);
        wr(NVT_IDX_DATA, 8'h3c);
        page(8'h18, 2);
        rd(NVT_IDX_CTRL, q);
        chk(q, 8'h20);
        chk({7'h0, irq_o}, 8'h00);
        rd(NVT_IDX_ADDR, q);
        chk(q, 8'h08);
        wr(NVT_IDX_ADDR, 8'h04);
        rd(NVT_IDX_DATA, q);
        chk(q, 8'h5a);
        rd(NVT_IDX_DATA, q);
        rd(NVT_IDX_DATA, q);
        chk(q, 8'h3c);
        // write page ors latch into byte
        wr(NVT_IDX_CTRL, 8'h00);
        wr(NVT_IDX_ADDR, 8'h04);
        wr(NVT_IDX_DATA, 8'h81);
        page(8'h14, 1);
        wr(NVT_IDX_ADDR, 8'h04);
        rd(NVT_IDX_DATA, q);
        chk(q, 8'hdb);
        // erase byte 0 only, neighbour and address kept
        wr(NVT_IDX_ADDR, 8'h04);
        wr(NVT_IDX_DATA, 8'h00);
        page(8'h1e, 1);
        rd(NVT_IDX_ADDR, q);
        chk(q, 8'h04);
        wr(NVT_IDX_ADDR, 8'h06);
        rd(NVT_IDX_DATA, q);
        chk(q, 8'h3c);
        wr(NVT_IDX_ADDR, 8'h04);
        rd(NVT_IDX_DATA, q);
        chk(q, 8'h00);
        // increment mode steps the byte select, stops at latch 3
        wr(NVT_IDX_CTRL, 8'h04);
        wr(NVT_IDX_ADDR, 8'h0a);
        wr(NVT_IDX_DATA, 8'h11);
        rd(NVT_IDX_ADDR, q);
        chk(q, 8'h0b);
        wr(NVT_IDX_DATA, 8'h22);
        rd(NVT_IDX_ADDR, q);
        chk(q, 8'h0b);
        // free-running timer, flag on every underflow
        wr(NVT_IDX_CTRL, 8'h00);
        wr(NVT_IDX_RELOAD, 8'h02);
        wr(NVT_IDX_CTRL, 8'h80);
        rd(NVT_IDX_COUNT, q);
        chk({7'h0, q <= 8'h02}, 8'h01);
        for (int r = 0; r < 2; r++) begin
            k = 0;
            c0 = 8'h00;
            while (c0[5] !== 1'b1 && k < 40) begin
                rd(NVT_IDX_CTRL, c0);
                k++;
            end
            chk(c0, 8'ha0);
            wr(NVT_IDX_CTRL, 8'h80);
        end
        wr(NVT_IDX_CTRL, 8'he0);
        repeat (2) @(negedge clk_i);
        chk({7'h0, irq_o}, 8'h01);
        // stopped count holds, restart from reload
        wr(NVT_IDX_CTRL, 8'h00);
        rd(NVT_IDX_COUNT, c0);
        repeat (20) @(posedge clk_i);
        rd(NVT_IDX_COUNT, q);
        chk(q, c0);
        wr(NVT_IDX_CTRL, 8'h40);
        repeat (2) @(negedge clk_i);
        chk({7'h0, irq_o}, 8'h00);
        wr(NVT_IDX_RELOAD, 8'hc8);
        wr(NVT_IDX_CTRL, 8'h80);
        rd(NVT_IDX_COUNT, q);
        chk({7'h0, q >= 8'hc6}, 8'h01);
        // stop mode freezes the count, resumes after
        @(posedge clk_i);
        stop_i <= 1'b1; // no cycle in progress
        rd(NVT_IDX_COUNT, c0);
        repeat (40) @(posedge clk_i);
        rd(NVT_IDX_COUNT, q);
        chk(q, c0);
        stop_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        rd(NVT_IDX_COUNT, q);
        chk({7'h0, q < c0 && q > c0 - 8'd14}, 8'h01);
        conclude();
    end
endmodule : nvt_ctrl_tb
`default_nettype wire
